// ### dv/pirf_evt_src.sv
// peripheral event sources driving one-cycle strobes into the flag bank
`timescale 1ns/100ps

module pirf_evt_src
(
    // clock
    input  wire logic        clk,
    // event requests, one bit per source
    input  wire logic [11:0] ev_req,
    // strobes into the flag bank
    output logic             gate,
    output logic [3:0]       capcmp,
    output logic             mem,
    output logic             osc,
    output logic [1:0]       wgen,
    output logic             pw,
    output logic             per,
    output logic             gen
);
    // ************************************************************
    // each request becomes a strobe one cycle later
    // ************************************************************
    always_ff @(posedge clk)
    begin
        {gen, per, pw, wgen, osc, mem, capcmp, gate} <= ev_req;
    end
endmodule : pirf_evt_src

// ### dv/tb_top.sv
// self-checking bench of the peripheral flag bank
`timescale 1ns/100ps
`include "pirf_defines.svh"

module tb_top;
    import pirf_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, gwr_s, gwd, gflag, irq;
    pirf_addr_t  reg_addr;
    pirf_byte_t  reg_wdata, reg_rdata, e6, e7, e8, m6, m7, m8;
    logic [11:0] ev_req;
    logic        s_gate, s_mem, s_osc, s_pw, s_per, s_gen, eg;
    logic [3:0]  s_cc;
    logic [1:0]  s_wg;
    logic [31:0] seed;
    int          num_errors, total_checks;

    pirf_evt_src u_pirf_evt_src (.clk(clk), .ev_req(ev_req), .gate(s_gate), .capcmp(s_cc),
        .mem(s_mem), .osc(s_osc), .wgen(s_wg), .pw(s_pw), .per(s_per), .gen(s_gen));
    pirf_flags u_pirf_flags (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_gate_done(s_gate), .capcmp_event(s_cc), .memory_op_done(s_mem),
        .numeric_osc_rollover(s_osc), .waveform_gen_shutdown(s_wg),
        .meas_timer_pulse_width(s_pw), .meas_timer_period(s_per), .meas_timer_general(s_gen),
        .gate_flag_wr(gwr_s), .gate_flag_wdata(gwd), .timer_one_gate_flag(gflag), .irq(irq));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic pirf_byte_t f6(input logic [11:0] v);
        return {4'h0, v[4:1]};
    endfunction : f6

    function automatic pirf_byte_t f7(input logic [11:0] v);
        return {2'h0, v[5], v[6], 2'h0, v[8:7]};
    endfunction : f7

    function automatic pirf_byte_t f8(input logic [11:0] v);
        return {5'h00, v[9], v[10], v[11]};
    endfunction : f8

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic check(input pirf_byte_t got, input pirf_byte_t exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input pirf_addr_t a, input pirf_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        ev_req <= 12'h000;
        @(posedge clk);
        reg_wr <= 1'b0;
        case (a)
            `PIRF_ADDR_CAPCMP: e6 = d & `PIRF_IMPL_CAPCMP;
            `PIRF_ADDR_MISC:   e7 = d & `PIRF_IMPL_MISC;
            `PIRF_ADDR_MEAS:   e8 = d & `PIRF_IMPL_MEAS;
            `PIRF_ADDR_MASK6:  m6 = d;
            `PIRF_ADDR_MASK7:  m7 = d;
            `PIRF_ADDR_MASK8:  m8 = d;
            default: ;
        endcase
    endtask : wr

    task automatic rd(input pirf_addr_t a, input pirf_byte_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd

    task automatic gw(input logic d);
        @(posedge clk);
        gwr_s <= 1'b1;
        gwd <= d;
        @(posedge clk);
        gwr_s <= 1'b0;
        eg = d;
    endtask : gw

    task automatic fire(input logic [11:0] v, input logic clash);
        @(posedge clk);
        ev_req <= v;
        if (clash)
            wr((|v[4:1]) ? `PIRF_ADDR_CAPCMP : ((|v[8:5]) ? `PIRF_ADDR_MISC : `PIRF_ADDR_MEAS),
               8'h00);
        else
        begin
            @(posedge clk);
            ev_req <= 12'h000;
            @(posedge clk);
        end
        e6 |= f6(v);
        e7 |= f7(v);
        e8 |= f8(v);
        eg |= v[0];
    endtask : fire

    task automatic chk_all();
        rd(`PIRF_ADDR_CAPCMP, e6);
        rd(`PIRF_ADDR_MISC, e7);
        rd(`PIRF_ADDR_MEAS, e8);
        rd(`PIRF_ADDR_MASK6, m6 & `PIRF_IMPL_CAPCMP);
        rd(`PIRF_ADDR_MASK7, m7 & `PIRF_IMPL_MISC);
        rd(`PIRF_ADDR_MASK8, m8 & `PIRF_IMPL_MEAS);
        check({7'h00, gflag}, {7'h00, eg});
        check({7'h00, irq}, {7'h00, |((e6 & m6) | (e7 & m7) | (e8 & m8))});
    endtask : chk_all

    task automatic clr_all();
        wr(`PIRF_ADDR_CAPCMP, 8'h00);
        wr(`PIRF_ADDR_MISC, 8'h00);
        wr(`PIRF_ADDR_MEAS, 8'h00);
        gw(1'b0);
    endtask : clr_all

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end

    initial
    begin
        {rst_n, reg_wr, reg_rd, gwr_s, gwd, reg_addr, reg_wdata, ev_req} = '0;
        {e6, e7, e8, m6, m7, m8, eg, num_errors, total_checks} = '0;
        seed = 32'hf001;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk_all();
        rd(12'h0715, 8'h00);
        // all-ones writes show implemented bits only
        for (int i = 0; i < 3; i++) wr(`PIRF_ADDR_CAPCMP + i[11:0], 8'hff);
        gw(1'b1);
        chk_all();
        clr_all();
        chk_all();
        // every source alone, masks clear
        for (int i = 0; i < 12; i++)
        begin
            fire(12'h001 << i, 1'b0);
            chk_all();
            clr_all();
        end
        // set against a clearing write in the same cycle
        for (int i = 0; i < 3; i++)
        begin
            fire(12'h001 << (i * 4 + 1), 1'b1);
            chk_all();
        end
        // stale flags cleared before any mask is opened
        clr_all();
        // random events, writes, masks and unmapped places
        for (int i = 0; i < 60; i++)
        begin
            fire(seed[11:0], seed[12] & seed[13]);
            seed = xs(seed);
            wr((seed[3] ? 12'h0720 : 12'h0712) + {10'h000, seed[5:4]}, seed[15:8]);
            if (seed[6])
                gw(seed[7]);
            seed = xs(seed);
            chk_all();
        end
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        {e6, e7, e8, m6, m7, m8, eg} = '0;
        repeat (3) @(posedge clk);
        chk_all();
        close_out();
    end
endmodule : tb_top

// ### hw/pirf_defines.svh
// register offsets, bit positions and reset values of the peripheral flag bank
`ifndef PIRF_DEFINES_SVH
`define PIRF_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define PIRF_ADDR_CAPCMP   12'h0712
`define PIRF_ADDR_MISC     12'h0713
`define PIRF_ADDR_MEAS     12'h0714
`define PIRF_ADDR_MASK6    12'h0720
`define PIRF_ADDR_MASK7    12'h0721
`define PIRF_ADDR_MASK8    12'h0722

// ************************************************************
// implemented bits
// ************************************************************
`define PIRF_IMPL_CAPCMP   8'h0f
`define PIRF_IMPL_MISC     8'h33
`define PIRF_IMPL_MEAS     8'h07
`define PIRF_IMPL_GATE     8'h01

// ************************************************************
// bit positions
// ************************************************************
`define PIRF_BIT_GATE      0
`define PIRF_BIT_CWG1      0
`define PIRF_BIT_CWG2      1
`define PIRF_BIT_OSC       4
`define PIRF_BIT_MEM       5
`define PIRF_BIT_MGEN      0
`define PIRF_BIT_MPER      1
`define PIRF_BIT_MPW       2

// ************************************************************
// reset values
// ************************************************************
`define PIRF_RST_BYTE      8'h00

`endif

// ### hw/pirf_flags.sv
// peripheral interrupt request flag bank with mask and interrupt output
// ************************************************************
// ************************************************************
`timescale 1ns/100ps

`include "pirf_defines.svh"

module pirf_flags
    import pirf_pkg::*;
#(
    parameter int unsigned NUM_CAPCMP = 4
)
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // register port
    input  wire pirf_pkg::pirf_addr_t   reg_addr,
    input  wire pirf_pkg::pirf_byte_t   reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output pirf_pkg::pirf_byte_t        reg_rdata,
    // event strobes, one cycle each
    input  wire logic                   timer_gate_done,
    input  wire logic [NUM_CAPCMP-1:0]  capcmp_event,
    input  wire logic                   memory_op_done,
    input  wire logic                   numeric_osc_rollover,
    input  wire logic [1:0]             waveform_gen_shutdown,
    input  wire logic                   meas_timer_pulse_width,
    input  wire logic                   meas_timer_period,
    input  wire logic                   meas_timer_general,
    // gate flag register, written through its own strobe
    input  wire logic                   gate_flag_wr,
    input  wire logic                   gate_flag_wdata,
    output logic                        timer_one_gate_flag,
    // interrupt
    output logic                        irq
);

    import pirf_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ************************************************************
    // flag set vectors
    // ************************************************************
    pirf_byte_t set_capcmp;
    pirf_byte_t set_misc;
    pirf_byte_t set_meas;

    always_comb
    begin
        set_capcmp = `PIRF_RST_BYTE;
        set_misc   = `PIRF_RST_BYTE;
        set_meas   = `PIRF_RST_BYTE;
        set_capcmp[NUM_CAPCMP-1:0] = capcmp_event;
        set_misc[`PIRF_BIT_MEM]    = memory_op_done;
        set_misc[`PIRF_BIT_OSC]    = numeric_osc_rollover;
        set_misc[`PIRF_BIT_CWG1]   = waveform_gen_shutdown[0];
        set_misc[`PIRF_BIT_CWG2]   = waveform_gen_shutdown[1];
        set_meas[`PIRF_BIT_MPW]    = meas_timer_pulse_width;
        set_meas[`PIRF_BIT_MPER]   = meas_timer_period;
        set_meas[`PIRF_BIT_MGEN]   = meas_timer_general;
    end

    // ************************************************************
    // write decode
    // ************************************************************
    logic wr_capcmp;
    logic wr_misc;
    logic wr_meas;
    logic wr_mask6;
    logic wr_mask7;
    logic wr_mask8;

    assign wr_capcmp = reg_wr && (reg_addr == `PIRF_ADDR_CAPCMP);
    assign wr_misc   = reg_wr && (reg_addr == `PIRF_ADDR_MISC);
    assign wr_meas   = reg_wr && (reg_addr == `PIRF_ADDR_MEAS);
    assign wr_mask6  = reg_wr && (reg_addr == `PIRF_ADDR_MASK6);
    assign wr_mask7  = reg_wr && (reg_addr == `PIRF_ADDR_MASK7);
    assign wr_mask8  = reg_wr && (reg_addr == `PIRF_ADDR_MASK8);

    // ************************************************************
    // flag registers
    // ************************************************************
    pirf_byte_t capture_compare_flags;
    pirf_byte_t misc_peripheral_flags;
    pirf_byte_t measurement_timer_flags;
    pirf_byte_t next_capcmp;
    pirf_byte_t next_misc;
    pirf_byte_t next_meas;
    logic       next_gate;

    // write stores the value, then any set strobe forces ones
    always_comb
    begin
        next_capcmp = wr_capcmp ? reg_wdata : capture_compare_flags;
        next_misc   = wr_misc   ? reg_wdata : misc_peripheral_flags;
        next_meas   = wr_meas   ? reg_wdata : measurement_timer_flags;
        next_gate   = gate_flag_wr ? gate_flag_wdata : timer_one_gate_flag;
        next_capcmp = (next_capcmp | set_capcmp) & `PIRF_IMPL_CAPCMP;
        next_misc   = (next_misc | set_misc) & `PIRF_IMPL_MISC;
        next_meas   = (next_meas | set_meas) & `PIRF_IMPL_MEAS;
        next_gate   = next_gate | timer_gate_done;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            capture_compare_flags   <= `PIRF_RST_BYTE;
            misc_peripheral_flags   <= `PIRF_RST_BYTE;
            measurement_timer_flags <= `PIRF_RST_BYTE;
            timer_one_gate_flag     <= 1'b0;
        end
        else
        begin
            capture_compare_flags   <= next_capcmp;
            misc_peripheral_flags   <= next_misc;
            measurement_timer_flags <= next_meas;
            timer_one_gate_flag     <= next_gate;
        end
    end

    // ************************************************************
    // mask registers
    // ************************************************************
    pirf_byte_t mask_capcmp;
    pirf_byte_t mask_misc;
    pirf_byte_t mask_meas;

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            mask_capcmp <= `PIRF_RST_BYTE;
            mask_misc   <= `PIRF_RST_BYTE;
            mask_meas   <= `PIRF_RST_BYTE;
        end
        else
        begin
            if (wr_mask6)
                mask_capcmp <= reg_wdata & `PIRF_IMPL_CAPCMP;
            if (wr_mask7)
                mask_misc <= reg_wdata & `PIRF_IMPL_MISC;
            if (wr_mask8)
                mask_meas <= reg_wdata & `PIRF_IMPL_MEAS;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    pirf_byte_t next_rdata;

    always_comb
    begin
        next_rdata = `PIRF_RST_BYTE;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `PIRF_ADDR_CAPCMP: next_rdata = capture_compare_flags;
                `PIRF_ADDR_MISC:   next_rdata = misc_peripheral_flags;
                `PIRF_ADDR_MEAS:   next_rdata = measurement_timer_flags;
                `PIRF_ADDR_MASK6:  next_rdata = mask_capcmp;
                `PIRF_ADDR_MASK7:  next_rdata = mask_misc;
                `PIRF_ADDR_MASK8:  next_rdata = mask_meas;
                default:           next_rdata = `PIRF_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rdata <= `PIRF_RST_BYTE;
        else
            reg_rdata <= next_rdata;
    end

    // ************************************************************
    // interrupt output
    // ************************************************************
    logic next_irq;

    assign next_irq = |(next_capcmp & mask_capcmp) || |(next_misc & mask_misc)
                   || |(next_meas & mask_meas);

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq <= 1'b0;
        else
            irq <= next_irq;
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_gate_set_wins: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        timer_gate_done |=> timer_one_gate_flag)
        else $error("gate flag not set after gate event");

    a_capcmp_set: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        capcmp_event[0] |=> capture_compare_flags[0])
        else $error("unit one flag not set after event");

    a_capcmp_hold: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (capture_compare_flags[3] && !wr_capcmp) |=> capture_compare_flags[3])
        else $error("unit four flag dropped without a write");

    a_capcmp_unused: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        capture_compare_flags[7:4] == 4'h0)
        else $error("unused capture bits not zero");

    a_misc_layout: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (misc_peripheral_flags & ~`PIRF_IMPL_MISC) == `PIRF_RST_BYTE)
        else $error("unused misc bits not zero");

    a_mem_done_set: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        memory_op_done |=> misc_peripheral_flags[5])
        else $error("memory flag not set");

    a_osc_set_clash: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (numeric_osc_rollover && wr_misc && !reg_wdata[4]) |=> misc_peripheral_flags[4])
        else $error("oscillator set lost against clear");

    a_shutdown_set: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        waveform_gen_shutdown[1] |=> misc_peripheral_flags[1])
        else $error("generator two flag not set");

    a_meas_hold: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (measurement_timer_flags[2] && !wr_meas) |=> measurement_timer_flags[2])
        else $error("pulse-width flag dropped without a write");

    a_meas_layout: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        meas_timer_period |=> measurement_timer_flags[1] && !measurement_timer_flags[7])
        else $error("period flag not at bit 1");

    a_sw_clear: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (wr_meas && !reg_wdata[0] && !meas_timer_general) |=> !measurement_timer_flags[0])
        else $error("software clear ignored");

    a_irq_follows: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (mask_capcmp == `PIRF_RST_BYTE && mask_misc == `PIRF_RST_BYTE
         && mask_meas == `PIRF_RST_BYTE && !wr_mask6 && !wr_mask7 && !wr_mask8)
        |=> !irq)
        else $error("interrupt raised with all masks clear");

    a_read_data: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (reg_rd && reg_addr == `PIRF_ADDR_MEAS) |=> reg_rdata == $past(measurement_timer_flags))
        else $error("read data wrong");

    a_gate_clear: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (gate_flag_wr && !gate_flag_wdata && !timer_gate_done) |=> !timer_one_gate_flag)
        else $error("gate flag not cleared by write");

    a_capcmp_edge: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        capcmp_event[1] |=> capture_compare_flags[1])
        else $error("unit two flag not set after event");

    a_capcmp_clash: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (capcmp_event[0] && wr_capcmp && !reg_wdata[0]) |=> capture_compare_flags[0])
        else $error("unit one set lost against clear");

    a_mem_clash: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (memory_op_done && wr_misc && !reg_wdata[`PIRF_BIT_MEM])
        |=> misc_peripheral_flags[`PIRF_BIT_MEM])
        else $error("memory set lost against clear");

    a_osc_set: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        numeric_osc_rollover |=> misc_peripheral_flags[`PIRF_BIT_OSC])
        else $error("oscillator flag not set");

    a_gen_one_set: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        waveform_gen_shutdown[0] |=> misc_peripheral_flags[`PIRF_BIT_CWG1])
        else $error("generator one flag not set");

    a_pw_clash: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (meas_timer_pulse_width && wr_meas && !reg_wdata[`PIRF_BIT_MPW])
        |=> measurement_timer_flags[`PIRF_BIT_MPW])
        else $error("pulse-width set lost against clear");

    a_meas_gen_set: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        meas_timer_general |=> measurement_timer_flags[`PIRF_BIT_MGEN])
        else $error("general timer flag not set");

    a_irq_held: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        (|(measurement_timer_flags & mask_meas) && !wr_meas && !wr_mask8) |=> irq)
        else $error("interrupt low with a masked-in flag set");

    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        !reg_rd |=> reg_rdata == `PIRF_RST_BYTE)
        else $error("read data not zero outside a read");

endmodule : pirf_flags

// ### hw/pirf_pkg.sv
// types of the peripheral flag bank
package pirf_pkg;
    typedef logic [11:0] pirf_addr_t;
    typedef logic [7:0]  pirf_byte_t;
endpackage : pirf_pkg
